// ### src/scb_consts.svh
`ifndef SCB_CONSTS_SVH
`define SCB_CONSTS_SVH

`define SCB_CLK_PERIOD_NS 10
`define SCB_TRP_NS 30
`define SCB_TRCD_NS 30
// Least times, so both round up to whole clock cycles.
`define SCB_TRP_CYC ((`SCB_TRP_NS + `SCB_CLK_PERIOD_NS - 1) / `SCB_CLK_PERIOD_NS)
`define SCB_TRCD_CYC ((`SCB_TRCD_NS + `SCB_CLK_PERIOD_NS - 1) / `SCB_CLK_PERIOD_NS)
`define SCB_TWR_CYC 2
`define SCB_TRC_CYC 7
`define SCB_TRSC_CYC 2

`define SCB_AUTOCLOSE_BIT 10
`define SCB_MODE_BT_BIT 3
`define SCB_MODE_CL_LSB 4
`define SCB_MODE_RST 7'h32
`define SCB_BL_FULL 3'h7
`define SCB_FULL_PAGE 10'h200

`endif

// ### src/scb_pkg.sv
package scb_pkg;

  typedef enum logic [3:0] {
    st_idle,
    st_activating,
    st_active,
    st_reading,
    st_writing,
    st_read_ac,
    st_write_ac,
    st_write_recov,
    st_precharging
  } scb_bank_state_t;

endpackage

// ### src/scb_bank_if.sv
`timescale 1ns/1ps
`default_nettype none

interface scb_bank_if
  import scb_pkg::*;
();
  logic            act;
  logic            col_rd;
  logic            col_wr;
  logic            close;
  logic            halt;
  logic            done;
  logic            autoclose;
  logic [11:0]     row;
  scb_bank_state_t state;
  logic [11:0]     open_row;

  modport ctl (
    output act, col_rd, col_wr, close, halt, done, autoclose, row,
    input  state, open_row
  );
  modport bank (
    input  act, col_rd, col_wr, close, halt, done, autoclose, row,
    output state, open_row
  );
endinterface

`default_nettype wire

// ### src/scb_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "scb_consts.svh"

module scb_bank
  import scb_pkg::*;
#(
  parameter int TRCD_CYC = `SCB_TRCD_CYC,
  parameter int TRP_CYC  = `SCB_TRP_CYC,
  parameter int TWR_CYC  = `SCB_TWR_CYC
) (
  input wire logic  ref_clk,
  input wire logic  rst_n,
  scb_bank_if.bank  bif
);

  scb_bank_state_t state_q;
  scb_bank_state_t state_d;
  scb_bank_state_t col_st;
  logic [7:0]      tmr_q;
  logic [7:0]      tmr_d;
  logic [11:0]     row_q;

  wire logic tmr_end = (tmr_q == 8'h0);
  wire logic col_new = bif.col_rd || bif.col_wr;
  wire logic in_burst = (state_q == st_reading) || (state_q == st_writing);

  assign col_st = bif.col_wr ? (bif.autoclose ? st_write_ac : st_writing)
                             : (bif.autoclose ? st_read_ac : st_reading);

  ////////////////////////////////////////////////////////////////////////
  // per-bank machine.
  always_comb begin
    state_d = state_q;
    tmr_d   = tmr_end ? tmr_q : tmr_q - 8'h1;
    case (state_q)
      st_idle: begin
        if (bif.act) begin
          state_d = st_activating;
          tmr_d   = 8'(TRCD_CYC - 1);
        end
      end
      st_activating: begin
        if (tmr_end) state_d = st_active;
      end
      st_active, st_reading, st_writing: begin
        if (bif.close) begin
          state_d = st_precharging;
          tmr_d   = 8'(TRP_CYC - 1);
        end else if (col_new) begin
          state_d = col_st;
        end else if (in_burst && (bif.done || bif.halt)) begin
          state_d = st_active;
        end
      end
      st_read_ac: begin
        if (bif.done) begin
          state_d = st_precharging;
          tmr_d   = 8'(TRP_CYC - 1);
        end
      end
      st_write_ac: begin
        if (bif.done) begin
          state_d = st_write_recov;
          tmr_d   = 8'(TWR_CYC - 1);
        end
      end
      st_write_recov: begin
        if (tmr_end) begin
          state_d = st_precharging;
          tmr_d   = 8'(TRP_CYC - 1);
        end
      end
      st_precharging: begin
        if (tmr_end) state_d = st_idle;
      end
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      tmr_q   <= 8'h0;
      row_q   <= 12'h0;
    end else begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      if (state_q == st_idle && bif.act) row_q <= bif.row;
    end
  end

  assign bif.state    = state_q;
  assign bif.open_row = row_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  bank_open_a: assert property (
    state_q == st_idle && bif.act |=> state_q == st_activating && row_q == $past(bif.row)
  ) else $error("Row open did not start activation.");

  rcd_wait_a: assert property (
    TRCD_CYC == 3 && state_q == st_idle && bif.act
    |=> (state_q == st_activating)[*3] ##1 state_q == st_active
  ) else $error("Activation delay wrong.");

  prech_wait_a: assert property (
    TRP_CYC == 3 && state_q == st_active && bif.close
    |=> (state_q == st_precharging)[*3] ##1 state_q == st_idle
  ) else $error("Precharge delay wrong.");

  read_close_a: assert property (
    state_q == st_read_ac && bif.done |=> state_q == st_precharging
  ) else $error("Read auto-close missed.");

  write_close_a: assert property (
    state_q == st_write_ac && bif.done |=> state_q == st_write_recov
  ) else $error("Write auto-close missed.");

  burst_close_a: assert property (
    in_burst && bif.close |=> state_q == st_precharging
  ) else $error("Close did not end burst.");

  new_access_a: assert property (
    in_burst && col_new && !bif.close |=> state_q == $past(col_st)
  ) else $error("Interrupting access not taken.");

  halt_burst_a: assert property (
    in_burst && bif.halt && !bif.close && !col_new |=> state_q == st_active
  ) else $error("Burst halt ignored.");

  burst_keep_a: assert property (
    in_burst && !bif.close && !col_new && !bif.halt && !bif.done |=> $stable(state_q)
  ) else $error("Burst dropped on idle cycle.");

endmodule

`default_nettype wire

// ### src/scb_cmd_bank_fsm.sv
`timescale 1ns/1ps
`default_nettype none
`include "scb_consts.svh"

// Overview of operation
// - Row open opens addressed row in idle bank.
// - Read starts burst; data after column latency.
// - Read with auto-close closes bank after burst.
// - Write takes burst-length words into open bank.
// - Write with auto-close closes bank after burst.
// - Bank close deactivates bank, ends running burst.
// - Close with auto-close bit closes every open bank; refused if a bank is activating or auto-closing.
// - Auto refresh uses internal counter, banks closed.
// - Auto refresh needs clock gating high twice.
// - Mode load needs bank, upper address low.
// - Self refresh entry on falling clock gating.
// - Self refresh exit on rising clock gating.
// - Idle: open latches row, close does nothing.
// - Mode load and refresh only when idle.
// - Active: access latches column and auto-close.
// - New access during plain read restarts burst.
// - New access during plain write restarts burst.
// - Deselect and no-operation let bursts continue.
// - Burst halt ends plain burst only.
// - Closing bank idles after precharge time.
// - Opening bank active after row-to-column delay.
module scb_cmd_bank_fsm
  import scb_pkg::*;
#(
  parameter int TRCD_CYC = `SCB_TRCD_CYC,
  parameter int TRP_CYC  = `SCB_TRP_CYC,
  parameter int TWR_CYC  = `SCB_TWR_CYC,
  parameter int TRC_CYC  = `SCB_TRC_CYC,
  parameter int TRSC_CYC = `SCB_TRSC_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic        cke,
  input  wire logic [1:0]  bank_select,
  input  wire logic [11:0] addr,
  output logic      [15:0] bank_states,
  output logic      [47:0] open_rows,
  output logic             data_strobe_q,
  output logic             burst_write_q,
  output logic      [1:0]  burst_bank_q,
  output logic      [8:0]  burst_col_q,
  output logic      [6:0]  mode_value_q,
  output logic      [13:0] refresh_addr_q,
  output logic             self_refresh_q,
  output logic             busy_q,
  output logic             illegal_cmd_q
);

  ////////////////////////////////////////////////////////////////////////
  // The controller runs on ref_clk, so the pins take one sampling stage.
  logic        cs_n_q;
  logic        cke_q;
  logic        cke_prev_q;
  logic [2:0]  rcw_q;
  logic [1:0]  ba_q;
  logic [11:0] addr_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_q     <= 1'b1;
      cke_q      <= 1'b1;
      cke_prev_q <= 1'b1;
      rcw_q      <= 3'h7;
      ba_q       <= 2'h0;
      addr_q     <= 12'h0;
    end else begin
      cs_n_q     <= cs_n;
      cke_q      <= cke;
      cke_prev_q <= cke_q;
      rcw_q      <= {ras_n, cas_n, we_n};
      ba_q       <= bank_select;
      addr_q     <= addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  busy_cnt_q;
  logic [2:0]  lat_q;
  logic [9:0]  left_q;
  logic        fp_q;
  logic [8:0]  beat_q;
  logic [8:0]  col_base_q;

  wire logic sel_w   = !cs_n_q && cke_prev_q && !self_refresh_q && !busy_q;
  wire logic nop_w   = !cs_n_q && rcw_q == 3'h7;
  wire logic is_act  = sel_w && rcw_q == 3'h3;
  wire logic is_rd   = sel_w && rcw_q == 3'h5;
  wire logic is_wr   = sel_w && rcw_q == 3'h4;
  wire logic is_pre  = sel_w && rcw_q == 3'h2;
  wire logic is_halt = sel_w && rcw_q == 3'h6;
  wire logic is_ref  = sel_w && rcw_q == 3'h1 && cke_q;
  wire logic is_mload  = sel_w && rcw_q == 3'h0 && ba_q == 2'h0 && addr_q[11:7] == 5'h0;
  wire logic bad_mload = sel_w && rcw_q == 3'h0 && !is_mload;
  wire logic is_sin  = !cs_n_q && cke_prev_q && !cke_q && rcw_q == 3'h1 && !self_refresh_q
                       && !busy_q;
  wire logic is_sout = self_refresh_q && !cke_prev_q && cke_q && (cs_n_q || nop_w);
  wire logic autoclose_flag_bit = addr_q[`SCB_AUTOCLOSE_BIT];

  ////////////////////////////////////////////////////////////////////////
  scb_bank_if      bif [4] ();
  scb_bank_state_t st [4];
  logic [3:0]      idle_m;
  logic [3:0]      open_m;
  logic [3:0]      quiet_m;
  logic [3:0]      burst_m;

  wire logic all_idle = &idle_m;
  wire logic act_go   = is_act && idle_m[ba_q];
  wire logic col_go   = (is_rd || is_wr) && open_m[ba_q];
  wire logic pre_go   = is_pre && !autoclose_flag_bit && open_m[ba_q];
  wire logic close_all_go = is_pre && autoclose_flag_bit && &(open_m | quiet_m);
  wire logic halt_go  = is_halt && burst_m[ba_q];
  wire logic ref_go   = is_ref && all_idle;
  wire logic mload_go = is_mload && all_idle;
  wire logic sin_go   = is_sin && all_idle;

  wire logic illegal_w = (is_act && !idle_m[ba_q]) || ((is_rd || is_wr) && !open_m[ba_q])
                       || (is_pre && !autoclose_flag_bit && !(open_m[ba_q] || quiet_m[ba_q]))
                       || (is_pre && autoclose_flag_bit && !close_all_go) || bad_mload
                       || (is_halt && !open_m[ba_q]) || (is_ref && !all_idle)
                       || (is_mload && !all_idle) || (is_sin && !all_idle);

  wire logic kill_w = halt_go || close_all_go || (pre_go && ba_q == burst_bank_q);
  // quiet cycles let the burst run out.
  wire logic done_w = !col_go && !kill_w && lat_q == 3'h0 && left_q == 10'h1 && !fp_q;

  generate
    for (genvar g = 0; g < 4; g++) begin : g_bank
      assign st[g]      = bif[g].state;
      assign idle_m[g]  = st[g] == st_idle;
      assign quiet_m[g] = st[g] == st_idle || st[g] == st_precharging;
      assign burst_m[g] = st[g] == st_reading || st[g] == st_writing;
      assign open_m[g]  = burst_m[g] || st[g] == st_active;
      assign bif[g].act       = act_go && ba_q == 2'(g);
      assign bif[g].col_rd    = col_go && is_rd && ba_q == 2'(g);
      assign bif[g].col_wr    = col_go && is_wr && ba_q == 2'(g);
      assign bif[g].close     = (pre_go && ba_q == 2'(g)) || (close_all_go && open_m[g]);
      assign bif[g].halt      = halt_go && ba_q == 2'(g);
      // One beat counter serves all banks, so an access elsewhere ends this burst.
      assign bif[g].done      = (done_w && burst_bank_q == 2'(g)) || (col_go && ba_q != 2'(g));
      assign bif[g].autoclose = autoclose_flag_bit;
      assign bif[g].row       = addr_q;
      assign bank_states[4*g +: 4] = bif[g].state;
      assign open_rows[12*g +: 12] = bif[g].open_row;

      scb_bank #(
        .TRCD_CYC (TRCD_CYC),
        .TRP_CYC  (TRP_CYC),
        .TWR_CYC  (TWR_CYC)
      ) u_bank (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .bif     (bif[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Mode field decode; reserved latencies fall back to two.
  wire logic [2:0] bl_code = mode_value_q[2:0];
  wire logic [2:0] cl_f    = mode_value_q[`SCB_MODE_CL_LSB +: 3];
  wire logic [2:0] cl_w    = (cl_f < 3'h2) ? 3'h2 : cl_f;
  wire logic [9:0] bl_w    = (bl_code == `SCB_BL_FULL) ? `SCB_FULL_PAGE
                                                        : (10'h1 << bl_code[1:0]);
  wire logic [9:0] bl_m1   = bl_w - 10'h1;
  wire logic [8:0] mask_w  = bl_m1[8:0];
  wire logic [8:0] seq_w   = col_base_q + beat_q;
  wire logic [8:0] pick_w  = mode_value_q[`SCB_MODE_BT_BIT] ? (col_base_q ^ beat_q) : seq_w;
  wire logic [8:0] col_nx  = (col_base_q & ~mask_w) | (pick_w & mask_w);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q         <= 3'h0;
      left_q        <= 10'h0;
      fp_q          <= 1'b0;
      beat_q        <= 9'h0;
      col_base_q    <= 9'h0;
      data_strobe_q <= 1'b0;
      burst_write_q <= 1'b0;
      burst_bank_q  <= 2'h0;
      burst_col_q   <= 9'h0;
    end else if (col_go) begin
      lat_q         <= is_wr ? 3'h0 : cl_w - 3'h1;
      left_q        <= bl_w;
      fp_q          <= bl_code == `SCB_BL_FULL;
      beat_q        <= 9'h0;
      col_base_q    <= addr_q[8:0];
      data_strobe_q <= 1'b0;
      burst_write_q <= is_wr;
      burst_bank_q  <= ba_q;
    end else if (kill_w) begin
      lat_q         <= 3'h0;
      left_q        <= 10'h0;
      data_strobe_q <= 1'b0;
    end else if (lat_q != 3'h0) begin
      lat_q         <= lat_q - 3'h1;
      data_strobe_q <= 1'b0;
    end else if (left_q != 10'h0) begin
      data_strobe_q <= 1'b1;
      burst_col_q   <= col_nx;
      beat_q        <= beat_q + 9'h1;
      if (!fp_q) left_q <= left_q - 10'h1;
    end else begin
      data_strobe_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Busy covers refresh and mode recovery; commands in it are dropped.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_value_q   <= `SCB_MODE_RST;
      refresh_addr_q <= 14'h0;
      self_refresh_q <= 1'b0;
      busy_q         <= 1'b0;
      busy_cnt_q     <= 8'h0;
      illegal_cmd_q  <= 1'b0;
    end else begin
      illegal_cmd_q <= illegal_w;
      if (mload_go) mode_value_q <= addr_q[6:0];
      if (ref_go) refresh_addr_q <= refresh_addr_q + 14'h1;
      if (sin_go) self_refresh_q <= 1'b1;
      else if (is_sout) self_refresh_q <= 1'b0;
      if (ref_go || is_sout) begin
        busy_cnt_q <= 8'(TRC_CYC - 1);
        busy_q     <= 1'b1;
      end else if (mload_go) begin
        busy_cnt_q <= 8'(TRSC_CYC - 1);
        busy_q     <= 1'b1;
      end else if (busy_cnt_q != 8'h0) begin
        busy_cnt_q <= busy_cnt_q - 8'h1;
      end else begin
        busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  wire logic quiet_w = !col_go && !kill_w;

  mode_load_a: assert property (
    mload_go |=> mode_value_q == $past(addr_q[6:0]) && busy_q
  ) else $error("Mode load not stored.");

  refresh_idle_a: assert property (
    is_ref && !all_idle |=> $stable(refresh_addr_q)
  ) else $error("Refresh taken with a bank open.");

  refresh_step_a: assert property (
    ref_go |=> refresh_addr_q == $past(refresh_addr_q) + 14'h1 && all_idle && busy_q
  ) else $error("Refresh counter not advanced.");

  sref_entry_a: assert property (
    sin_go |=> self_refresh_q
  ) else $error("Self refresh not entered.");

  sref_exit_a: assert property (
    is_sout |=> !self_refresh_q && busy_q
  ) else $error("Self refresh not left.");

  read_lat_a: assert property (
    (col_go && is_rd && cl_w == 3'h3) ##1 quiet_w[*3]
    |=> data_strobe_q && !$past(data_strobe_q) && !burst_write_q
  ) else $error("Read data not at latency.");

  write_len_a: assert property (
    (col_go && is_wr && bl_code == 3'h2) ##1 quiet_w[*5]
    |-> !$past(data_strobe_q, 4) && $past(data_strobe_q, 3) && data_strobe_q
        ##1 !data_strobe_q
  ) else $error("Write burst length wrong.");

  close_all_a: assert property (
    close_all_go |=> open_m == 4'h0
  ) else $error("Close all left a bank open.");

endmodule

`default_nettype wire

// ### tb/scb_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

module scb_ctl_model (
  input  wire logic        ref_clk,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic             cke,
  output logic [1:0]       bank_select,
  output logic [11:0]      addr
);
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    cke = 1'b1;
    bank_select = 2'h0;
    addr = 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock gating kept
  // callers keep order
  // A command stands one cycle, then a deselect follows. Address and bank are
  // inverted then, so a stale value is never mistaken for a live one.
  task automatic issue(input logic [3:0] sig, input logic [1:0] ba,
                       input logic [11:0] a, input logic ck);
    @(posedge ref_clk);
    {cs_n, ras_n, cas_n, we_n} <= sig;
    bank_select <= ba;
    addr <= a;
    cke <= ck;
    @(posedge ref_clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    bank_select <= ~ba;
    addr <= ~a;
  endtask
endmodule

`default_nettype wire

// ### tb/scb_cmd_bank_fsm_tb.sv
`timescale 1ns/1ps
`default_nettype none

module scb_cmd_bank_fsm_tb;
  import scb_pkg::*;
  localparam logic [3:0] ROW_OPEN = 4'b0011, RD = 4'b0101, WR = 4'b0100;
  localparam logic [3:0] PRE = 4'b0010, REF = 4'b0001, MODE_LD = 4'b0000;
  localparam logic [3:0] HALT = 4'b0110;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n, ras_n, cas_n, we_n, cke;
  logic [1:0]  bank_select;
  logic [11:0] addr;
  logic [15:0] bank_states;
  logic [47:0] open_rows;
  logic        data_strobe_q, burst_write_q, self_refresh_q, busy_q, illegal_cmd_q;
  logic [1:0]  burst_bank_q;
  logic [8:0]  burst_col_q;
  logic [6:0]  mode_value_q;
  logic [13:0] refresh_addr_q;
  int          n_mismatch = 0;
  int          total_checks = 0;

  always #5 ref_clk = ~ref_clk;

  scb_cmd_bank_fsm scb_cmd_bank_fsm_inst (
    .ref_clk, .rst_n, .cs_n, .ras_n, .cas_n, .we_n, .cke, .bank_select, .addr,
    .bank_states, .open_rows, .data_strobe_q, .burst_write_q, .burst_bank_q,
    .burst_col_q, .mode_value_q, .refresh_addr_q, .self_refresh_q, .busy_q,
    .illegal_cmd_q
  );

  scb_ctl_model scb_ctl_model_inst (
    .ref_clk, .cs_n, .ras_n, .cas_n, .we_n, .cke, .bank_select, .addr
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [3:0] st(input int b);
    return bank_states[4*b +: 4];
  endfunction

  task automatic go(input logic [3:0] s, input logic [1:0] b, input logic [11:0] a);
    scb_ctl_model_inst.issue(s, b, a, 1'b1);
  endtask

  // Precharge and recovery lengths vary, so the wait is bounded, not exact.
  task automatic wait_idle(input int b);
    for (int i = 0; i < 12 && st(b) !== st_idle; i++) step(1);
    chk(st(b), st_idle);
  endtask

  task automatic wait_free;
    for (int i = 0; i < 20 && busy_q !== 1'b0; i++) step(1);
    chk(busy_q, 1'b0);
  endtask

  task automatic t_open(input int b, input logic [11:0] row);
    go(ROW_OPEN, 2'(b), row);
    step(1);
    chk(st(b), st_activating);
    chk(open_rows[12*b +: 12], row);
    step(2);
    chk(st(b), st_activating);
    step(1);
    chk(st(b), st_active);
    $display("open test done");
  endtask

  // Default mode: four beats, sequential, column latency three.
  task automatic t_burst(input int b, input logic [8:0] col, input logic wr,
                         input logic ac);
    logic [1:0] j;
    go(wr ? WR : RD, 2'(b), {1'b0, ac, 1'b0, col});
    step(1);
    chk(st(b), wr ? (ac ? st_write_ac : st_writing) : (ac ? st_read_ac : st_reading));
    step(wr ? 1 : 3);
    for (int i = 0; i < 4; i++) begin
      j = col[1:0] + 2'(i);
      chk(data_strobe_q, 1'b1);
      chk(burst_col_q, {col[8:2], j});
      chk({burst_write_q, burst_bank_q}, {wr, 2'(b)});
      if (i == 3 && !ac) chk(st(b), st_active);
      step(1);
    end
    chk(data_strobe_q, 1'b0);
    if (ac) wait_idle(b);
    $display("burst test done");
  endtask

  task automatic t_cut(input int b);
    go(RD, 2'(b), 12'h010);
    step(1);
    go(WR, 2'(b), 12'h020);
    step(1);
    chk(st(b), st_writing);
    step(1);
    chk({data_strobe_q, burst_col_q}, {1'b1, 9'h020});
    step(3);
    chk(st(b), st_active);
    go(RD, 2'(b), 12'h030);
    go(HALT, 2'(b), 12'h000);
    step(1);
    chk(st(b), st_active);
    step(1);
    chk(data_strobe_q, 1'b0);
    go(HALT, 2'(b), 12'h000);
    step(1);
    chk({illegal_cmd_q, st(b)}, {1'b0, st_active});
    go(RD, 2'(b), 12'h040);
    go(PRE, 2'(b), 12'h000);
    step(1);
    chk({data_strobe_q, st(b)}, {1'b0, st_precharging});
    step(1);
    chk(st(b), st_precharging);
    wait_idle(b);
    go(PRE, 2'(b), 12'h000);
    step(1);
    chk({illegal_cmd_q, bank_states}, 17'h0);
    $display("interrupt test done");
  endtask

  task automatic t_all;
    t_open(0, 12'hc35);
    go(ROW_OPEN, 2'h0, 12'h001);
    step(1);
    chk({illegal_cmd_q, open_rows[11:0]}, {1'b1, 12'hc35});
    t_open(2, 12'h3ca);
    go(PRE, 2'h3, 12'h400);
    step(1);
    chk({st(0), st(2)}, {st_precharging, st_precharging});
    wait_idle(0);
    wait_idle(2);
    $display("close all test done");
  endtask

  task automatic t_refresh;
    logic [13:0] r;
    t_open(3, 12'h0f0);
    r = refresh_addr_q;
    go(REF, 2'h0, 12'h000);
    step(1);
    chk({illegal_cmd_q, refresh_addr_q}, {1'b1, r});
    go(PRE, 2'h3, 12'h000);
    wait_idle(3);
    go(REF, 2'h0, 12'h000);
    step(1);
    chk(refresh_addr_q, r + 14'h1);
    chk({busy_q, bank_states}, 17'h10000);
    wait_free;
    $display("refresh test done");
  endtask

  task automatic t_mode;
    go(MODE_LD, 2'h0, 12'h080);
    step(1);
    chk({illegal_cmd_q, mode_value_q}, {1'b1, 7'h32});
    go(MODE_LD, 2'h0, 12'h023);
    step(1);
    chk({busy_q, mode_value_q}, {1'b1, 7'h23});
    wait_free;
    $display("mode test done");
  endtask

  // Eight interleaved beats at latency two, then a full page stopped by a halt.
  task automatic t_ilv;
    go(MODE_LD, 2'h0, 12'h02b);
    step(1);
    wait_free;
    t_open(0, 12'h246);
    go(RD, 2'h0, 12'h00d);
    step(3);
    for (int i = 0; i < 8; i++) begin
      chk({data_strobe_q, burst_col_q}, {1'b1, 6'h01, 3'h5 ^ 3'(i)});
      step(1);
    end
    chk({data_strobe_q, st(0)}, {1'b0, st_active});
    go(PRE, 2'h0, 12'h000);
    wait_idle(0);
    go(MODE_LD, 2'h0, 12'h027);
    step(1);
    wait_free;
    t_open(0, 12'h135);
    go(RD, 2'h0, 12'h1fe);
    step(3);
    chk({data_strobe_q, burst_col_q}, {1'b1, 9'h1fe});
    step(1);
    chk({data_strobe_q, burst_col_q}, {1'b1, 9'h1ff});
    go(HALT, 2'h0, 12'h000);
    step(1);
    chk({data_strobe_q, st(0)}, {1'b0, st_active});
    go(PRE, 2'h0, 12'h000);
    wait_idle(0);
    $display("mode burst test done");
  endtask

  task automatic t_self;
    scb_ctl_model_inst.issue(REF, 2'h0, 12'h000, 1'b0);
    step(1);
    chk(self_refresh_q, 1'b1);
    step(3);
    chk(self_refresh_q, 1'b1);
    scb_ctl_model_inst.issue(4'hf, 2'h0, 12'h000, 1'b1);
    step(1);
    chk(self_refresh_q, 1'b0);
    wait_free;
    $display("self refresh test done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    step(1);
    chk({bank_states, mode_value_q}, {16'h0, 7'h32});
    chk({data_strobe_q, busy_q, illegal_cmd_q, self_refresh_q}, 4'h0);
    t_open(1, 12'h5a3);
    t_burst(1, 9'h005, 1'b0, 1'b0);
    t_burst(1, 9'h102, 1'b1, 1'b0);
    t_burst(1, 9'h0a9, 1'b0, 1'b1);
    t_open(1, 12'h777);
    t_burst(1, 9'h1fe, 1'b1, 1'b1);
    t_open(1, 12'h111);
    t_cut(1);
    t_all;
    t_refresh;
    t_mode;
    t_ilv;
    t_self;
    test_done;
  end

  // Whole run takes well under a thousand cycles.
  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end
endmodule

`default_nettype wire
